// ==== rtl/power_mode_pkg.sv ====
// =====================================================================
// Shared constants for the power mode and pin state block
package power_mode_pkg;

  // =====================================================================
  // Register bus
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [11:0] OFS_POWER_CTRL = 12'h000;
  localparam logic [11:0] OFS_POWERSAVE = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PIN_FUNC = 12'h00c;

  // Power control fields
  localparam int unsigned BIT_IDLE = 0;
  localparam int unsigned BIT_PDOWN = 1;
  // Powersave fields: divide by field value plus one
  localparam int unsigned PS_DIV_W = 6;
  localparam int unsigned PS_DIV_LSB = 0;
  localparam int unsigned BIT_PS_EN = 8;
  localparam logic [5:0] PS_DIV_RST = 6'h00;
  // Status fields
  localparam int unsigned ST_IDLE = 0;
  localparam int unsigned ST_PDOWN = 1;
  localparam int unsigned ST_PSAVE = 2;
  localparam int unsigned ST_TEST = 3;
  localparam int unsigned ST_HOLD = 4;
  // Pin function field: port bit 0 as serial receive
  localparam int unsigned BIT_P3_SERIAL = 0;

  // =====================================================================
  // Pins
  localparam int unsigned LOW_AD_W = 13;

  // Power state, Gray along active, idle, powerdown
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_PDOWN = 2'b11
  } pwr_state_e;

  // State applied to an output pin
  typedef enum logic [2:0] {
    PIN_HIGH = 3'h0,
    PIN_LOW = 3'h1,
    PIN_FLOAT = 3'h2,
    PIN_ACTIVE = 3'h3,
    PIN_RETAIN = 3'h4,
    PIN_WEAK_HIGH = 3'h5
  } pin_state_e;

  // Per pin: hold, reset, idle, powerdown
  localparam pin_state_e AD_HOLD = PIN_FLOAT;
  localparam pin_state_e AD_RESET = PIN_FLOAT;
  localparam pin_state_e AD_IDLE = PIN_LOW;
  localparam pin_state_e AD_PDOWN = PIN_LOW;
  localparam pin_state_e A19_HOLD = PIN_FLOAT;
  localparam pin_state_e A19_RESET = PIN_WEAK_HIGH;
  localparam pin_state_e A19_IDLE = PIN_LOW;
  localparam pin_state_e A19_PDOWN = PIN_LOW;
  localparam pin_state_e P3_PORT_HOLD = PIN_RETAIN;
  localparam pin_state_e P3_SER_HOLD = PIN_ACTIVE;
  localparam pin_state_e P3_RESET = PIN_FLOAT;
  localparam pin_state_e P3_IDLE = PIN_ACTIVE;
  localparam pin_state_e P3_PDOWN = PIN_RETAIN;

endpackage : power_mode_pkg

// ==== rtl/clock_prescaler.sv ====
`timescale 1ns/10ps
// =====================================================================
// Tick generator: one tick every ratio+1 cycles, every cycle when off
module clock_prescaler #(
  parameter int unsigned DIV_W = power_mode_pkg::PS_DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [DIV_W-1:0] ratio,
  output logic tick
);

  logic [DIV_W-1:0] cnt_q; // Cycles since last tick
  logic [DIV_W-1:0] cnt_d;
  logic wrap; // Count reached the ratio

  // Greater-or-equal so a smaller ratio written mid-count takes at pin_float_test_mode
  assign wrap = (cnt_q >= ratio);
  assign tick = !enable || wrap;
  assign cnt_d = tick ? '0 : cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};

  // Counter register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : clock_prescaler

// ==== rtl/pin_state_driver.sv ====
`timescale 1ns/10ps
// =====================================================================
// Registered pin driver that applies one pin state to a group of pins
module pin_state_driver #(
  parameter int unsigned W = 1,
  parameter power_mode_pkg::pin_state_e RST_STATE = power_mode_pkg::PIN_FLOAT
) (
  input wire logic pclk,
  input wire logic presetn,
  input power_mode_pkg::pin_state_e state,
  input wire logic [W-1:0] core_out,
  input wire logic [W-1:0] core_oe_n,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n,
  output logic pin_weak
);

  // Reset levels are constants derived from the reset state
  localparam logic RST_OUT = (RST_STATE == power_mode_pkg::PIN_HIGH) ||
                             (RST_STATE == power_mode_pkg::PIN_WEAK_HIGH);
  localparam logic RST_OE_N = !((RST_STATE == power_mode_pkg::PIN_HIGH) ||
                                (RST_STATE == power_mode_pkg::PIN_LOW));
  localparam logic RST_WEAK = (RST_STATE == power_mode_pkg::PIN_WEAK_HIGH);

  logic [W-1:0] out_q;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_n_q;
  logic [W-1:0] oe_n_d;
  logic weak_q;
  logic weak_d;
  logic is_hi; // Strong high or weak high level
  logic is_drv; // Strongly driven state

  assign is_hi = (state == power_mode_pkg::PIN_HIGH) || (state == power_mode_pkg::PIN_WEAK_HIGH);
  assign is_drv = (state == power_mode_pkg::PIN_HIGH) || (state == power_mode_pkg::PIN_LOW);
  // Retain and float keep the last level; a floated level is not seen
  assign out_d = is_hi ? '1 :
                 (state == power_mode_pkg::PIN_LOW) ? '0 :
                 (state == power_mode_pkg::PIN_ACTIVE) ? core_out : out_q;
  assign oe_n_d = is_drv ? '0 :
                  (state == power_mode_pkg::PIN_ACTIVE) ? core_oe_n :
                  (state == power_mode_pkg::PIN_RETAIN) ? oe_n_q : '1;
  assign weak_d = (state == power_mode_pkg::PIN_WEAK_HIGH);

  // Pin registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= {W{RST_OUT}};
      oe_n_q <= {W{RST_OE_N}};
      weak_q <= RST_WEAK;
    end
    else
    begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      weak_q <= weak_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
  assign pin_weak = weak_q;

endmodule : pin_state_driver

// ==== rtl/power_mode_pin_state_control.sv ====
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - Active mode clocks all units at half rate
// - Idle holds execution and bus clocks low
// - Powerdown holds internal clocks low, oscillator off; output clock keeps its level
// - Powersave divides internal clocks by prescaler, up to 64
// - Powersave works in idle and active modes
// - Test strap low during reset floats pins
// - Test strap pin weakly pulled high in reset
// - Test mode floats all but crystal drive
// - Every output pin has per-mode defined state
// - Address/data float in hold, reset; low in idle, powerdown
// - Output clock runs at half rate, even duty
module power_mode_pin_state_control (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the core side
  input wire logic hold_ack_i,
  input wire logic wake_i,
  // Internal unit clocks, oscillator enable and output clock pin
  output logic exec_clk,
  output logic bus_clk,
  output logic periph_clk,
  output logic crystal_drive_en,
  output logic output_clock_pin_o,
  output logic output_clock_pin_oe_n,
  // Low address/data pins
  input wire logic [12:0] core_ad_o,
  input wire logic [12:0] core_ad_oe_n,
  output logic [12:0] low_address_data_pins_o,
  output logic [12:0] low_address_data_pins_oe_n,
  // Address 19 / status / test strap pin
  input wire logic core_a19_o,
  input wire logic core_a19_oe_n,
  input wire logic address19_status_test_pin_i,
  output logic address19_status_test_pin_o,
  output logic address19_status_test_pin_oe_n,
  output logic address19_status_test_pin_weak,
  // Port 3 bit 0 / serial 1 receive
  input wire logic core_port3_bit0_o,
  input wire logic core_port3_bit0_oe_n,
  output logic port3_bit0_o,
  output logic port3_bit0_oe_n
);

  // =====================================================================
  // Register bus decode
  logic setup_ph; // Setup cycle of a transfer
  logic access_ph; // Access cycle, always answered at pin_float_test_mode
  logic hit_ctrl;
  logic hit_psave;
  logic hit_status;
  logic hit_func;
  logic hit_any;
  logic wr_ctrl; // Write to power control takes effect
  logic wr_psave;
  logic wr_func;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_ctrl = (paddr == power_mode_pkg::OFS_POWER_CTRL);
  assign hit_psave = (paddr == power_mode_pkg::OFS_POWERSAVE);
  assign hit_status = (paddr == power_mode_pkg::OFS_STATUS);
  assign hit_func = (paddr == power_mode_pkg::OFS_PIN_FUNC);
  assign hit_any = hit_ctrl || hit_psave || hit_status || hit_func;
  assign wr_ctrl = access_ph && pwrite && hit_ctrl;
  assign wr_psave = access_ph && pwrite && hit_psave;
  assign wr_func = access_ph && pwrite && hit_func;
  // Zero wait states; unmapped addresses get an error
  assign pready = 1'b1;
  assign pslverr = access_ph && !hit_any;

  // =====================================================================
  // Control state
  power_mode_pkg::pwr_state_e pwr_q; // Current power state
  power_mode_pkg::pwr_state_e pwr_d;
  logic ps_en_q; // Powersave division on
  logic [5:0] ps_div_q; // Division ratio minus one
  logic p3_serial_q; // Port bit works as serial receive
  logic in_reset_q; // First cycle after reset release
  logic test_mode_q; // Pin float test mode latched from strap
  logic hold_q; // Bus hold acknowledge seen
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] psave_word;

  // Next power state: a write wins over a wake in the same cycle
  always_comb
  begin
    pwr_d = pwr_q;
    if (wr_ctrl)
    begin
      if (pwdata[power_mode_pkg::BIT_PDOWN])
        pwr_d = power_mode_pkg::PWR_PDOWN;
      else if (pwdata[power_mode_pkg::BIT_IDLE])
        pwr_d = power_mode_pkg::PWR_IDLE;
      else
        pwr_d = power_mode_pkg::PWR_ACTIVE;
    end
    else
    begin
      case (pwr_q)
        power_mode_pkg::PWR_ACTIVE: pwr_d = power_mode_pkg::PWR_ACTIVE;
        power_mode_pkg::PWR_IDLE: pwr_d = wake_i ? power_mode_pkg::PWR_ACTIVE : pwr_q;
        power_mode_pkg::PWR_PDOWN: pwr_d = wake_i ? power_mode_pkg::PWR_ACTIVE : pwr_q;
        default: pwr_d = power_mode_pkg::PWR_ACTIVE;
      endcase
    end
  end

  // Power state and software settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_q <= power_mode_pkg::PWR_ACTIVE;
      ps_en_q <= 1'b0;
      ps_div_q <= power_mode_pkg::PS_DIV_RST;
      p3_serial_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      if (wr_psave)
      begin
        ps_en_q <= pwdata[power_mode_pkg::BIT_PS_EN];
        ps_div_q <= pwdata[power_mode_pkg::PS_DIV_LSB +: power_mode_pkg::PS_DIV_W];
      end
      if (wr_func)
        p3_serial_q <= pwdata[power_mode_pkg::BIT_P3_SERIAL];
    end
  end

  // Strap capture in the first cycle after release, never in reset itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_reset_q <= 1'b1;
      test_mode_q <= 1'b0;
    end
    else
    begin
      in_reset_q <= 1'b0;
      if (in_reset_q)
        test_mode_q <= !address19_status_test_pin_i;
    end
  end

  // Hold acknowledge is a synchronous input, taken each cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 1'b0;
    else
      hold_q <= hold_ack_i;
  end

  // =====================================================================
  // Read path, loaded in setup so data comes from a flop
  assign ctrl_word = {30'h0, pwr_q == power_mode_pkg::PWR_PDOWN,
                      pwr_q == power_mode_pkg::PWR_IDLE};
  assign psave_word = {23'h0, ps_en_q, 2'h0, ps_div_q};
  assign status_word = {27'h0, hold_q, test_mode_q, ps_en_q,
                        pwr_q == power_mode_pkg::PWR_PDOWN,
                        pwr_q == power_mode_pkg::PWR_IDLE};
  assign rd_data = hit_ctrl ? ctrl_word :
                   hit_psave ? psave_word :
                   hit_status ? status_word :
                   hit_func ? {31'h0, p3_serial_q} : 32'h0;

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup_ph)
      prdata_q <= pwrite ? 32'h0 : rd_data;
  end

  assign prdata = prdata_q;

  // =====================================================================
  // Clock generation
  logic tick; // Prescaler step
  logic phase_q; // Half-rate phase
  logic phase_d;
  logic is_idle;
  logic is_pdown;
  logic exec_q;
  logic bus_q;
  logic periph_q;
  logic osc_en_q;
  logic output_clock_pin_q;
  logic output_clock_pin_oe_n_q;

  assign is_idle = (pwr_q == power_mode_pkg::PWR_IDLE);
  assign is_pdown = (pwr_q == power_mode_pkg::PWR_PDOWN);

  // Divider shared by every internal clock
  clock_prescaler #(
    .DIV_W(power_mode_pkg::PS_DIV_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ps_en_q),
    .ratio(ps_div_q),
    .tick(tick)
  );

  // Phase toggles per tick, so one tick per cycle gives half rate
  assign phase_d = is_pdown ? 1'b0 : (tick ? !phase_q : phase_q);

  // Internal clocks are flops so no gate can glitch them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= 1'b0;
      exec_q <= 1'b0;
      bus_q <= 1'b0;
      periph_q <= 1'b0;
      osc_en_q <= 1'b1;
    end
    else
    begin
      phase_q <= phase_d;
      exec_q <= phase_d && !is_idle && !is_pdown;
      bus_q <= phase_d && !is_idle && !is_pdown;
      periph_q <= phase_d;
      osc_en_q <= !is_pdown;
    end
  end

  // Output clock keeps running except in powerdown, where it retains
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_clock_pin_q <= 1'b0;
      output_clock_pin_oe_n_q <= 1'b0;
    end
    else
    begin
      output_clock_pin_q <= is_pdown ? output_clock_pin_q : !output_clock_pin_q;
      output_clock_pin_oe_n_q <= test_mode_q;
    end
  end

  assign exec_clk = exec_q;
  assign bus_clk = bus_q;
  assign periph_clk = periph_q;
  assign crystal_drive_en = osc_en_q;
  assign output_clock_pin_o = output_clock_pin_q;
  assign output_clock_pin_oe_n = output_clock_pin_oe_n_q;

  // =====================================================================
  // Pin state selection
  // Priority: test float, reset, hold, powerdown, idle, normal
  function automatic power_mode_pkg::pin_state_e pick_state(
    input logic tst,
    input logic rst,
    input logic hld,
    input power_mode_pkg::pwr_state_e pw,
    input power_mode_pkg::pin_state_e h,
    input power_mode_pkg::pin_state_e r,
    input power_mode_pkg::pin_state_e i,
    input power_mode_pkg::pin_state_e p
  );
    if (tst)
      return power_mode_pkg::PIN_FLOAT;
    else if (rst)
      return r;
    else if (hld)
      return h;
    else if (pw == power_mode_pkg::PWR_PDOWN)
      return p;
    else if (pw == power_mode_pkg::PWR_IDLE)
      return i;
    else
      return power_mode_pkg::PIN_ACTIVE;
  endfunction : pick_state

  power_mode_pkg::pin_state_e ad_st;
  power_mode_pkg::pin_state_e a19_st;
  power_mode_pkg::pin_state_e p3_st;
  power_mode_pkg::pin_state_e p3_hold_st;

  assign ad_st = pick_state(test_mode_q, in_reset_q, hold_q, pwr_q, power_mode_pkg::AD_HOLD,
                            power_mode_pkg::AD_RESET, power_mode_pkg::AD_IDLE,
                            power_mode_pkg::AD_PDOWN);
  assign a19_st = pick_state(test_mode_q, in_reset_q, hold_q, pwr_q, power_mode_pkg::A19_HOLD,
                             power_mode_pkg::A19_RESET, power_mode_pkg::A19_IDLE,
                             power_mode_pkg::A19_PDOWN);
  // Hold behaviour follows the selected function
  assign p3_hold_st = p3_serial_q ? power_mode_pkg::P3_SER_HOLD
                                  : power_mode_pkg::P3_PORT_HOLD;
  assign p3_st = pick_state(test_mode_q, in_reset_q, hold_q, pwr_q, p3_hold_st,
                            power_mode_pkg::P3_RESET, power_mode_pkg::P3_IDLE,
                            power_mode_pkg::P3_PDOWN);

  // Address/data group
  pin_state_driver #(
    .W(power_mode_pkg::LOW_AD_W),
    .RST_STATE(power_mode_pkg::AD_RESET)
  ) u_ad_pins (
    .pclk(pclk),
    .presetn(presetn),
    .state(ad_st),
    .core_out(core_ad_o),
    .core_oe_n(core_ad_oe_n),
    .pin_out(low_address_data_pins_o),
    .pin_oe_n(low_address_data_pins_oe_n),
    .pin_weak()
  );

  // Strap pin, weakly high in reset
  pin_state_driver #(
    .W(1),
    .RST_STATE(power_mode_pkg::A19_RESET)
  ) u_a19_pin (
    .pclk(pclk),
    .presetn(presetn),
    .state(a19_st),
    .core_out(core_a19_o),
    .core_oe_n(core_a19_oe_n),
    .pin_out(address19_status_test_pin_o),
    .pin_oe_n(address19_status_test_pin_oe_n),
    .pin_weak(address19_status_test_pin_weak)
  );

  // Multifunction port pin; serial receive never drives
  pin_state_driver #(
    .W(1),
    .RST_STATE(power_mode_pkg::P3_RESET)
  ) u_p3_pin (
    .pclk(pclk),
    .presetn(presetn),
    .state(p3_st),
    .core_out(core_port3_bit0_o),
    .core_oe_n(core_port3_bit0_oe_n || p3_serial_q),
    .pin_out(port3_bit0_o),
    .pin_oe_n(port3_bit0_oe_n),
    .pin_weak()
  );

  // =====================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [5:0] gap_q; // Cycles since last tick
  logic steady_q; // Division unchanged since a tick

  // Helper counters read only by assertions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q <= 6'h00;
      steady_q <= 1'b0;
    end
    else
    begin
      gap_q <= tick ? 6'h00 : gap_q + 6'h01;
      steady_q <= wr_psave ? 1'b0 : (tick ? 1'b1 : steady_q);
    end
  end

  sequence active_two_s;
    (pwr_q == power_mode_pkg::PWR_ACTIVE && !ps_en_q) [*2];
  endsequence

  sequence idle_psave_s;
    (is_idle && ps_en_q) [*2];
  endsequence

  half_rate_a: assert property (active_two_s |=> periph_clk != $past(periph_clk))
    else $error("Active clock does not toggle every cycle");
  idle_stop_a: assert property (is_idle |=> !exec_clk && !bus_clk)
    else $error("Core clocks run in idle");
  pdown_stop_a: assert property (is_pdown |=> !periph_clk && !exec_clk && !crystal_drive_en)
    else $error("Clock or oscillator running in powerdown");
  psave_gap_a: assert property (tick && ps_en_q && steady_q |-> gap_q == ps_div_q)
    else $error("Prescaler tick spacing wrong");
  psave_idle_a: assert property (idle_psave_s |=> (periph_clk != $past(periph_clk)) == $past(tick))
    else $error("Peripheral clock ignores prescaler in idle");
  test_entry_a: assert property (in_reset_q |=> test_mode_q == !$past(address19_status_test_pin_i))
    else $error("Test strap not captured");
  reset_pull_a: assert property (in_reset_q |-> address19_status_test_pin_weak && address19_status_test_pin_oe_n)
    else $error("Strap pin not weakly high in reset");
  test_float_a: assert property (test_mode_q |=> (&low_address_data_pins_oe_n) && address19_status_test_pin_oe_n && port3_bit0_oe_n && output_clock_pin_oe_n)
    else $error("Pin driven in test mode");
  ad_idle_a: assert property (is_idle && !hold_q && !test_mode_q && !in_reset_q |=> low_address_data_pins_oe_n == 13'h0000 && low_address_data_pins_o == 13'h0000)
    else $error("Address/data not low in idle");
  ad_hold_a: assert property (hold_q && !test_mode_q |=> &low_address_data_pins_oe_n)
    else $error("Address/data driven in hold");
  p3_hold_a: assert property (hold_q && !p3_serial_q && !test_mode_q && !in_reset_q |=> $stable(port3_bit0_o) && $stable(port3_bit0_oe_n))
    else $error("Port bit changes in hold");
  output_clock_pin_a: assert property (!is_pdown |=> output_clock_pin_o != $past(output_clock_pin_o))
    else $error("Output clock not toggling");
  reset_start_a: assert property (in_reset_q |-> pwr_q == power_mode_pkg::PWR_ACTIVE && !ps_en_q)
    else $error("Not active after reset");

endmodule : power_mode_pin_state_control

// ==== verif/board_pins.sv ====
`timescale 1ns/10ps
// =====================================================================
// Board side of the strap pin: pull-up in reset, test fixture may pull low
module board_pins (
  input wire logic pclk,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  input wire logic pin_weak,
  input wire logic strap_low,
  output logic pin_level
);
  // A released wire with no pull shows a changing value, never the last one
  logic junk_q = 1'b0;
  always @(posedge pclk)
  begin
    junk_q <= ~junk_q;
  end
  // Design drive first, then the fixture, then the weak pull-up
  assign pin_level = !pin_oe_n ? pin_o : strap_low ? 1'b0 : pin_weak ? 1'b1 : junk_q;
endmodule : board_pins

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  // =====================================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_ack_i, wake_i;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic exec_clk, bus_clk, periph_clk, crystal_drive_en, output_clock_pin_o;
  logic output_clock_pin_oe_n, core_a19_o, core_a19_oe_n, address19_status_test_pin_i;
  logic address19_status_test_pin_o, address19_status_test_pin_oe_n;
  logic address19_status_test_pin_weak, core_port3_bit0_o, core_port3_bit0_oe_n;
  logic port3_bit0_o, port3_bit0_oe_n, strap, er;
  logic [12:0] core_ad_o, core_ad_oe_n, low_address_data_pins_o, low_address_data_pins_oe_n;
  int n_errors = 0, checks = 0, tp, te, to;
  // =====================================================================
  // Design, board and clock
  power_mode_pin_state_control power_mode_pin_state_control_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hold_ack_i, .wake_i,
    .exec_clk, .bus_clk, .periph_clk, .crystal_drive_en, .output_clock_pin_o,
    .output_clock_pin_oe_n, .core_ad_o, .core_ad_oe_n, .low_address_data_pins_o,
    .low_address_data_pins_oe_n, .core_a19_o, .core_a19_oe_n, .address19_status_test_pin_i,
    .address19_status_test_pin_o, .address19_status_test_pin_oe_n,
    .address19_status_test_pin_weak, .core_port3_bit0_o, .core_port3_bit0_oe_n,
    .port3_bit0_o, .port3_bit0_oe_n);
  board_pins board_pins_i (.pclk, .pin_o(address19_status_test_pin_o),
    .pin_oe_n(address19_status_test_pin_oe_n), .pin_weak(address19_status_test_pin_weak),
    .strap_low(strap), .pin_level(address19_status_test_pin_i));
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // =====================================================================
  // Tasks
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Counts level changes of the unit clocks over n cycles
  task clk_run(input int n);
    logic p, e, o, b;
    tp = 0; te = 0; to = 0;
    p = periph_clk; e = exec_clk; o = output_clock_pin_o; b = bus_clk;
    repeat (n)
    begin
      @(posedge pclk);
      tp += int'(periph_clk !== p); te += int'(exec_clk !== e || bus_clk !== b);
      to += int'(output_clock_pin_o !== o);
      p = periph_clk; e = exec_clk; o = output_clock_pin_o; b = bus_clk;
    end
  endtask : clk_run
  // Reset with the strap fixture pulling low or not; strap sampled after release
  task do_reset(input logic s);
    strap <= s; presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("ad_oe_n", 32'h1fff, 32'(low_address_data_pins_oe_n));
    chk("a19_weak", 1, 32'(address19_status_test_pin_weak));
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    strap <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // =====================================================================
  // Tests
  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; hold_ack_i = 0; wake_i = 0;
    core_ad_o = 13'h1a5; core_ad_oe_n = 0; core_a19_o = 1; core_a19_oe_n = 0;
    core_port3_bit0_o = 1; core_port3_bit0_oe_n = 0; strap = 0; presetn = 0;
    do_reset(1'b0);
    apb(0, power_mode_pkg::OFS_POWER_CTRL, 0); chk("ctrl", 0, rd);
    apb(0, power_mode_pkg::OFS_POWERSAVE, 0); chk("psave", 0, rd);
    apb(0, power_mode_pkg::OFS_STATUS, 0); chk("status", 0, rd);
    chk("ad_o", 32'h1a5, 32'(low_address_data_pins_o));
    clk_run(16); chk("periph", 16, tp); chk("oclk", 16, to); chk("exec", 16, te);
    hold_ack_i <= 1'b1; @(posedge pclk);
    core_port3_bit0_o <= 1'b0; repeat (2) @(posedge pclk);
    chk("hold_oe_n", 32'h1fff, 32'(low_address_data_pins_oe_n));
    chk("p3_hold", 32'h2, 32'({port3_bit0_o, port3_bit0_oe_n}));
    apb(0, power_mode_pkg::OFS_STATUS, 0); chk("st_hold", 32'h10, rd);
    hold_ack_i <= 1'b0; repeat (3) @(posedge pclk);
    chk("p3_act", 0, 32'(port3_bit0_o));
    apb(1, power_mode_pkg::OFS_PIN_FUNC, 1); apb(0, power_mode_pkg::OFS_PIN_FUNC, 0);
    chk("func", 1, rd); chk("p3_ser", 1, 32'(port3_bit0_oe_n));
    apb(1, power_mode_pkg::OFS_POWER_CTRL, 1); repeat (3) @(posedge pclk);
    clk_run(16); chk("idle_exec", 0, te); chk("idle_periph", 16, tp);
    chk("exec_lo", 0, 32'({exec_clk, bus_clk}));
    chk("idle_ad", 0, 32'({low_address_data_pins_o, low_address_data_pins_oe_n}));
    chk("idle_a19", 0, 32'(address19_status_test_pin_o));
    apb(1, power_mode_pkg::OFS_POWERSAVE, 32'h13f); repeat (130) @(posedge pclk);
    clk_run(256); chk("ps64", 4, tp); chk("ps_exec", 0, te);
    apb(1, power_mode_pkg::OFS_POWER_CTRL, 0);
    apb(1, power_mode_pkg::OFS_POWERSAVE, 32'h101); repeat (8) @(posedge pclk);
    clk_run(256); chk("ps2", 128, tp);
    apb(1, power_mode_pkg::OFS_POWERSAVE, 0);
    apb(1, power_mode_pkg::OFS_POWER_CTRL, 2); repeat (3) @(posedge pclk);
    clk_run(16); chk("pd_clk", 0, tp + te);
    chk("pd_lvl", 0, 32'({periph_clk, exec_clk, crystal_drive_en}));
    chk("pd_ad", 0, 32'(low_address_data_pins_o));
    wake_i <= 1'b1; @(posedge pclk); wake_i <= 1'b0; repeat (4) @(posedge pclk);
    apb(0, power_mode_pkg::OFS_STATUS, 0); chk("woke", 0, rd);
    apb(0, 12'h010, 0); chk("unmapped", 0, rd); chk("slverr", 1, 32'(er));
    do_reset(1'b1);
    chk("float", 32'hffff, 32'({low_address_data_pins_oe_n, address19_status_test_pin_oe_n,
      port3_bit0_oe_n, output_clock_pin_oe_n}));
    chk("xtal", 1, 32'(crystal_drive_en));
    apb(0, power_mode_pkg::OFS_STATUS, 0); chk("st_test", 32'h8, rd);
    end_sim();
  end
  // Watchdog well beyond the fewer than a thousand cycles the tests need
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : tb_top
